// ===== inc/arp_pkg.sv
// Shared constants and types for the ADC result post-processing block.
// Assumes a 32-bit APB register bus and one 200 MHz clock.
package arp_pkg;

	localparam int ARP_ACC_W = 24;
	localparam int ARP_ADDR_W = 8;

	// Register byte offsets.
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_POST = 8'h00;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_THR0 = 8'h04;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_THR1 = 8'h08;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_UPPER = 8'h0c;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_LOWER = 8'h10;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_ACCUM = 8'h14;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_RESULT = 8'h18;
	localparam logic [ARP_ADDR_W-1:0] ARP_OFF_STATUS = 8'h1c;

	// Field positions.
	localparam int ARP_POST_RSV_BIT = 7;
	localparam int ARP_ST_HIT_BIT = 0;
	localparam int ARP_ST_NEW_BIT = 1;
	localparam int ARP_ST_W = 2;

	// Reset values.
	localparam logic [6:0] ARP_POST_RST = 7'h00;
	localparam logic [ARP_ACC_W-1:0] ARP_THR_RST = 24'h000000;
	localparam logic [2:0] ARP_ACCUM_RST = 3'h0;

	// Threshold compare selections.
	localparam logic [1:0] ARP_SEL_OFF = 2'h0;
	localparam logic [1:0] ARP_SEL_T0 = 2'h1;
	localparam logic [1:0] ARP_SEL_T1 = 2'h2;
	localparam logic [1:0] ARP_SEL_WIN = 2'h3;

	// Largest value of the narrow unsigned output.
	localparam logic [ARP_ACC_W-1:0] ARP_U16_MAX = 24'h00ffff;

	// Layout follows the low seven bits of the post-processing register.
	typedef struct packed {
		logic size24;
		logic [2:0] shift;
		logic pol;
		logic [1:0] sel;
	} arp_cfg_t;

	typedef struct packed {
		logic [ARP_ACC_W-1:0] t0;
		logic [ARP_ACC_W-1:0] t1;
		logic [ARP_ACC_W-1:0] upper;
		logic [ARP_ACC_W-1:0] lower;
	} arp_thr_t;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [ARP_ACC_W-1:0] value;
	} arp_res_t;

endpackage

// ===== rtl/arp_post.sv
// Top of the ADC result post-processing block with its APB register file.
// Assumes raw samples come from logic on ref_clk as one-cycle strobes.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Output size bit 0 gives 16-bit unsigned result, 1 gives 24-bit signed.
// - Accumulated sum is shifted right by the three-bit shift field.
// - Polarity 0 with one threshold: event when the shifted, sized result exceeds the threshold.
// - Polarity 1 with one threshold: event when the shifted, sized result is below the threshold.
// - Select 0 disables compare, 1 uses threshold zero, 2 threshold one.
// - Select 3 compares against the upper/lower window; polarity picks exit or entry.
// - Repeated samples are summed in a 24-bit accumulator before shift and sizing.
module arp_post
	import arp_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ARP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Raw samples.
	input wire logic sample_valid,
	input wire logic [ARP_ACC_W-1:0] sample_data,
	// Results.
	output logic result_valid,
	output logic [ARP_ACC_W-1:0] result_value,
	output logic threshold_event
);

	arp_cfg_t cfg_q;
	arp_thr_t thr_q;
	arp_res_t res;
	logic [2:0] accum_log2_q;
	logic [ARP_ACC_W-1:0] acc_q;
	logic [7:0] cnt_q;
	logic [ARP_ST_W-1:0] st_q;
	logic [ARP_ST_W-1:0] st_set;
	logic [ARP_ST_W-1:0] st_clr;
	logic [ARP_ACC_W-1:0] acc_sum;
	logic acc_done;
	logic wr_en;
	logic mapped;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;

	function automatic logic at(input logic [ARP_ADDR_W-1:0] a, input logic [ARP_ADDR_W-1:0] off);
		at = (a == off);
	endfunction

	// Single-cycle access phase keeps the master model trivial; there is no wait state.
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign mapped = at(paddr, ARP_OFF_POST) || at(paddr, ARP_OFF_THR0) || at(paddr, ARP_OFF_THR1)
		|| at(paddr, ARP_OFF_UPPER) || at(paddr, ARP_OFF_LOWER) || at(paddr, ARP_OFF_ACCUM)
		|| at(paddr, ARP_OFF_RESULT) || at(paddr, ARP_OFF_STATUS);
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			cfg_q <= arp_cfg_t'(ARP_POST_RST);
		else if (wr_en && at(paddr, ARP_OFF_POST))
			cfg_q <= arp_cfg_t'(pwdata[6:0]);
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			thr_q.t0 <= ARP_THR_RST;
			thr_q.t1 <= ARP_THR_RST;
			thr_q.upper <= ARP_THR_RST;
			thr_q.lower <= ARP_THR_RST;
		end
		else if (wr_en)
		begin
			if (at(paddr, ARP_OFF_THR0))
				thr_q.t0 <= pwdata[ARP_ACC_W-1:0];
			else if (at(paddr, ARP_OFF_THR1))
				thr_q.t1 <= pwdata[ARP_ACC_W-1:0];
			else if (at(paddr, ARP_OFF_UPPER))
				thr_q.upper <= pwdata[ARP_ACC_W-1:0];
			else if (at(paddr, ARP_OFF_LOWER))
				thr_q.lower <= pwdata[ARP_ACC_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			accum_log2_q <= ARP_ACCUM_RST;
		else if (wr_en && at(paddr, ARP_OFF_ACCUM))
			accum_log2_q <= pwdata[2:0];
	end

	// The sum wraps at 24 bits; software picks the accumulation count so that it never needs to.
	assign acc_sum = acc_q + sample_data;
	assign acc_done = sample_valid && (cnt_q == 8'(({1'b0, 8'h01} << accum_log2_q) - 9'h001));

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_q <= '0;
			cnt_q <= '0;
		end
		else if (acc_done)
		begin
			acc_q <= '0;
			cnt_q <= '0;
		end
		else if (sample_valid)
		begin
			acc_q <= acc_sum;
			cnt_q <= cnt_q + 8'h01;
		end
	end

	arp_shape u_shape (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(acc_done),
		.in_sum(acc_sum),
		.cfg(cfg_q),
		.thr(thr_q),
		.res(res)
	);

	assign result_valid = res.valid;
	assign result_value = res.value;
	assign threshold_event = res.valid && res.hit;

	// A new event in the cycle of its write-one clear still sets the flag.
	assign st_set = {res.valid, threshold_event};
	assign st_clr = (wr_en && at(paddr, ARP_OFF_STATUS)) ? pwdata[ARP_ST_W-1:0] : '0;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= (st_q & ~st_clr) | st_set;
	end

	always_comb
	begin
		prdata_d = '0;
		if (at(paddr, ARP_OFF_POST))
			prdata_d = {24'h000000, 1'b0, cfg_q};
		else if (at(paddr, ARP_OFF_THR0))
			prdata_d = {8'h00, thr_q.t0};
		else if (at(paddr, ARP_OFF_THR1))
			prdata_d = {8'h00, thr_q.t1};
		else if (at(paddr, ARP_OFF_UPPER))
			prdata_d = {8'h00, thr_q.upper};
		else if (at(paddr, ARP_OFF_LOWER))
			prdata_d = {8'h00, thr_q.lower};
		else if (at(paddr, ARP_OFF_ACCUM))
			prdata_d = {29'h0, accum_log2_q};
		else if (at(paddr, ARP_OFF_RESULT))
			prdata_d = {8'h00, res.value};
		else if (at(paddr, ARP_OFF_STATUS))
			prdata_d = {30'h0, st_q};
	end

	// Read data is captured in the setup cycle, so it comes from a flop and still needs no wait state.
	// A status flag that sets during the access cycle shows up on the following read.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			prdata_q <= '0;
		else if (psel && !penable)
			prdata_q <= prdata_d;
	end

	assign prdata = prdata_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	size16_a: assert property (acc_done && !cfg_q.size24 |=> res.valid && res.value <= ARP_U16_MAX)
		else $error("narrow result above 16 bits");

	size24_a: assert property (acc_done && cfg_q.size24 && cfg_q.shift == 3'h0 |=> res.value == $past(acc_sum))
		else $error("wide result differs from sum");

	shift_a: assert property (acc_done && cfg_q.size24 |=>
		$signed(res.value) == ($signed($past(acc_sum)) >>> $past(cfg_q.shift)))
		else $error("shift amount wrong");

	above_a: assert property (acc_done && cfg_q.sel == ARP_SEL_T0 && !cfg_q.pol ##1 $stable(thr_q.t0)
		|-> res.hit == ($signed(res.value) > $signed(thr_q.t0)))
		else $error("above threshold event wrong");

	below_a: assert property (acc_done && cfg_q.sel == ARP_SEL_T1 && cfg_q.pol ##1 $stable(thr_q.t1)
		|-> res.hit == ($signed(res.value) < $signed(thr_q.t1)))
		else $error("below threshold event wrong");

	compare_off_a: assert property (acc_done && cfg_q.sel == ARP_SEL_OFF |=> !threshold_event)
		else $error("event with compare disabled");

	window_exit_a: assert property (acc_done && cfg_q.sel == ARP_SEL_WIN && !cfg_q.pol
		##1 ($stable(thr_q.upper) && $stable(thr_q.lower))
		|-> res.hit == ($signed(res.value) > $signed(thr_q.upper) || $signed(res.value) < $signed(thr_q.lower)))
		else $error("window exit event wrong");

	window_enter_a: assert property (acc_done && cfg_q.sel == ARP_SEL_WIN && cfg_q.pol
		##1 ($stable(thr_q.upper) && $stable(thr_q.lower))
		|-> res.hit == ($signed(res.value) >= $signed(thr_q.lower) && $signed(res.value) <= $signed(thr_q.upper)))
		else $error("window entry event wrong");

	accum_clear_a: assert property (acc_done |=> acc_q == '0 && cnt_q == '0)
		else $error("accumulator not cleared after dump");

	accum_single_a: assert property (accum_log2_q == 3'h0 && sample_valid |-> acc_done)
		else $error("single sample did not dump");

	flag_set_a: assert property (threshold_event |=> st_q[ARP_ST_HIT_BIT])
		else $error("event flag lost");

	dump_c: cover property (acc_done ##1 result_valid);
	event_c: cover property (threshold_event && cfg_q.sel == ARP_SEL_WIN);
	clear_race_c: cover property (threshold_event && st_clr[ARP_ST_HIT_BIT]);
	narrow_clamp_c: cover property (acc_done && !cfg_q.size24 ##1 result_value == ARP_U16_MAX);

endmodule

// ===== rtl/arp_shape.sv
// Shift, output sizing and threshold compare of one accumulated sum.
// Assumes the sum arrives as a one-cycle strobe; the result is registered.
`timescale 1ns/1ps
module arp_shape
	import arp_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Accumulated sum.
	input wire logic in_valid,
	input wire logic [ARP_ACC_W-1:0] in_sum,
	// Settings.
	input wire arp_cfg_t cfg,
	input wire arp_thr_t thr,
	// Result.
	output arp_res_t res
);

	logic signed [ARP_ACC_W-1:0] shifted;
	logic signed [ARP_ACC_W-1:0] val;
	logic hit;

	always_comb
	begin
		shifted = $signed(in_sum) >>> cfg.shift;
		if (cfg.size24)
			val = shifted;
		else if (shifted < 0)
			val = '0;
		else if (shifted > $signed(ARP_U16_MAX))
			val = $signed(ARP_U16_MAX);
		else
			val = shifted;
	end

	// The narrow result clamps rather than wraps, so a too-small shift reads as full scale.
	always_comb
	begin
		hit = 1'b0;
		case (cfg.sel)
			ARP_SEL_T0:
				hit = cfg.pol ? (val < $signed(thr.t0)) : (val > $signed(thr.t0));
			ARP_SEL_T1:
				hit = cfg.pol ? (val < $signed(thr.t1)) : (val > $signed(thr.t1));
			ARP_SEL_WIN:
				hit = cfg.pol ? (val >= $signed(thr.lower) && val <= $signed(thr.upper))
					: (val > $signed(thr.upper) || val < $signed(thr.lower));
			default:
				hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			res.valid <= 1'b0;
		else
			res.valid <= in_valid;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			res.value <= '0;
			res.hit <= 1'b0;
		end
		else if (in_valid)
		begin
			res.value <= val;
			res.hit <= hit;
		end
	end

endmodule

// ===== sim/arp_host.sv
// Host model that reaches the post-processing registers over APB.
// Assumes the bench calls its tasks from one process on ref_clk.
`timescale 1ns/1ps
module arp_host
	import arp_pkg::*;
(
	// Clock.
	input wire logic ref_clk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ARP_ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end

	// Raw transfer; the request stands until pready is seen high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Polite write: the reserved top bit of the setup register goes out as zero.
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1, a, (a == ARP_OFF_POST) ? d & 32'h7f : d, r, e);
	endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the post-processing block against a model that queues its expected results.
// Assumes the host model drives APB and the bench drives raw samples.
`timescale 1ns/1ps
module testbench;
	import arp_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn, psel, penable, pwrite, pready, pslverr;
	logic [24:0] exp_q[$];
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic sample_valid, result_valid, threshold_event, e;
	logic [23:0] sample_data, result_value;
	logic signed [23:0] th[4];
	logic signed [23:0] acc, x;
	logic [24:0] ex;
	arp_cfg_t c;
	int n_fail, cmp_count, i, j, k, acc_n;

	arp_post i_arp_post(.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .sample_data(sample_data), .result_valid(result_valid),
		.result_value(result_value), .threshold_event(threshold_event));
	arp_host i_arp_host(.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always #2.5 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic er;
		i_arp_host.xfer(0, a, 32'h0, r, er);
		chk(r, exp);
		chk({31'h0, er}, {31'h0, eexp});
	endtask

	// Returns the event flag above the sized value.
	function automatic logic [24:0] model(arp_cfg_t cf, int s);
		int v;
		logic h;
		v = s >>> cf.shift;
		if (!cf.size24)
			v = (v < 0) ? 0 : ((v > 65535) ? 65535 : v);
		case (cf.sel)
			2'h1: h = cf.pol ? (v < int'(th[0])) : (v > int'(th[0]));
			2'h2: h = cf.pol ? (v < int'(th[1])) : (v > int'(th[1]));
			2'h3: h = cf.pol ? (v >= int'(th[3]) && v <= int'(th[2])) : (v > int'(th[2]) || v < int'(th[3]));
			default: h = 0;
		endcase
		return {h, v[23:0]};
	endfunction

	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_fail++;
		summarize;
	end

	initial
	begin
		resetn = 0;
		sample_valid = 0;
		sample_data = 0;
		void'($urandom(32'hc49f));
		repeat (3) @(posedge ref_clk);
		resetn <= 1;
		reg_chk(ARP_OFF_POST, 32'h0, 0);
		reg_chk(8'h20, 32'h0, 1);
		// The host breaks the reserved bit on purpose here.
		i_arp_host.xfer(1, ARP_OFF_POST, 32'hff, d, e);
		reg_chk(ARP_OFF_POST, 32'h7f, 0);
		for (i = 0; i < 32; i++)
		begin
			c = 7'($urandom);
			c.sel = i[1:0];
			acc_n = (i < 8) ? 7 : int'($urandom % 4);
			for (j = 0; j < 4; j++)
			begin
				th[j] = 24'($urandom % 131072 - 32768);
				i_arp_host.put(8'(4 * j + 4), {8'h0, th[j]});
			end
			i_arp_host.put(ARP_OFF_ACCUM, 32'(acc_n));
			i_arp_host.put(ARP_OFF_POST, {25'h0, c});
			acc = 0;
			for (k = 0; k < (1 << acc_n); k++)
			begin
				x = 24'($urandom % 262144 - 65536);
				@(posedge ref_clk);
				sample_valid <= 1;
				sample_data <= x;
				acc = acc + x;
			end
			@(posedge ref_clk);
			sample_valid <= 0;
			exp_q.push_back(model(c, int'(acc)));
			k = 0;
			do
			begin
				@(negedge ref_clk);
				k++;
			end
			while (result_valid !== 1'b1 && k < 4);
			ex = exp_q.pop_front();
			chk({31'h0, result_valid}, 32'h1);
			chk({8'h0, result_value}, {8'h0, ex[23:0]});
			chk({31'h0, threshold_event}, {31'h0, ex[24]});
			reg_chk(ARP_OFF_RESULT, {8'h0, ex[23:0]}, 0);
			reg_chk(ARP_OFF_STATUS, {30'h0, 1'b1, ex[24]}, 0);
			i_arp_host.put(ARP_OFF_STATUS, 32'h3);
		end
		summarize;
	end
endmodule
